// File: core/ftx_tx_pcs.sv
// transmit coding path of a 100 Mb/s twisted-pair physical layer
`timescale 1ns/1ps
`include "ftx_cfg.svh"

module ftx_tx_pcs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // mac transmit side
  input  wire logic        tx_en,
  input  wire logic [3:0]  txd,
  input  wire logic        tx_er,
  output logic             tx_nib_take,
  // mac carrier and collision
  input  wire logic        rx_active,
  output logic             crs,
  output logic             col,
  // line drive streams
  output logic             line_p,
  output logic             line_n,
  // loopback stream toward the receive path
  output logic             lb_bit,
  output logic             lb_valid
);

  // ============================================================
  // declarations
  // software visible state
  logic [15:0]          basic_mode_control_reg_r;
  logic [1:0]           txcfg_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  // group pacing and sequencing
  logic [2:0]           slot_r;
  logic                 slot_end;
  ftx_pkg::ftx_state_t  state_r;
  ftx_pkg::ftx_state_t  state_nxt;
  ftx_pkg::ftx_code_t   shift_r;
  ftx_pkg::ftx_code_t   code_nxt;
  // mode decode
  logic                 loop_on;
  logic                 speed100;
  logic                 full_dup;
  logic                 byp_enc;
  logic                 byp_scr;
  // carrier and collision
  logic                 tx_busy;
  logic                 crs_r;
  logic                 col_r;

  ftx_ser_if ser ();

  // ============================================================
  // write decode, shared by both register processes
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // ============================================================
  // 4b/5b data table
  // control groups j, k, t, r and idle come from the sequencer, not here
  // data code table
  function automatic ftx_pkg::ftx_code_t enc_4b5b(input logic [3:0] nib);
    ftx_pkg::ftx_code_t cg;
    cg = `FTX_CG_IDLE;
    unique case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      4'hF: cg = 5'h1D;
    endcase
    return cg;
  endfunction

  // ============================================================
  // configuration decode
  // the encoder bypass acts at the next group boundary, the scrambler bypass at once, mid group too
  assign loop_on  = basic_mode_control_reg_r[`FTX_MODE_CTRL_LOOP];
  assign speed100 = basic_mode_control_reg_r[`FTX_MODE_CTRL_SPEED];
  assign full_dup = basic_mode_control_reg_r[`FTX_MODE_CTRL_DUPLEX];
  assign byp_enc  = txcfg_r[`FTX_CFG_BYP_ENC];
  assign byp_scr  = txcfg_r[`FTX_CFG_BYP_SCR];

  // ============================================================
  // register writes
  // basic mode control: only the loopback, speed and duplex bits hold
  // reserved bits are dropped at the write, so a read never shows them
  // loopback control bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      basic_mode_control_reg_r <= `FTX_MODE_CTRL_RST;
    end else if (wr_hit(reg_wr, reg_addr, `FTX_OFS_MODE_CTRL)) begin
      basic_mode_control_reg_r <= reg_wdata[15:0] & `FTX_MODE_CTRL_WMASK;
    end
  end

  // transmit configuration: the two bypass switches
  // busy and state fields are read-only, writes to them are dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txcfg_r <= `FTX_CFG_RST;
    end else if (wr_hit(reg_wr, reg_addr, `FTX_OFS_TXCFG)) begin
      txcfg_r <= reg_wdata[1:0];
    end
  end

  // ============================================================
  // register reads: data stand in the cycle after the strobe only
  // registered so the bus never sees a path from the sequencer,
  // at the cost of one cycle of read latency
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `FTX_OFS_MODE_CTRL: begin
          rdata_nxt[15:0] = basic_mode_control_reg_r;
        end
        `FTX_OFS_PHYSTS: begin
          rdata_nxt[`FTX_STS_LOOP]    = loop_on;
          rdata_nxt[`FTX_STS_DUPLEX]  = full_dup;
          rdata_nxt[`FTX_STS_SPEED10] = ~speed100;
        end
        `FTX_OFS_TXCFG: begin
          rdata_nxt[1:0]                    = txcfg_r;
          rdata_nxt[`FTX_CFG_ACT]           = tx_busy;
          rdata_nxt[`FTX_CFG_STATE_LSB+:3]  = state_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;  // unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ============================================================
  // code-group slot timing: one serial bit per clock, five per group
  // a slot counter, not a divided clock, paces the mac, so the whole
  // path stays in one clock domain
  // nibble to serial
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_r <= 3'h0;
    end else if (slot_end) begin
      slot_r <= 3'h0;
    end else begin
      slot_r <= slot_r + 3'h1;
    end
  end

  // the mac nibble is taken in the last bit time of every group
  assign slot_end    = (slot_r == `FTX_SLOT_LAST);
  assign tx_nib_take = slot_end;

  // ============================================================
  // transmit sequencer, next state and next code-group
  // enable is only looked at on group boundaries: a drop in mid group
  // ends the frame at the next boundary and never splits a group;
  // the two nibbles under the start pair are dropped on purpose
  // standard transmit machine
  always_comb begin
    state_nxt = state_r;
    code_nxt  = `FTX_CG_IDLE;
    if (byp_enc) begin
      state_nxt = ftx_pkg::FTX_IDLE;
      code_nxt  = {tx_er, txd};
    end else begin
      unique case (state_r)
        ftx_pkg::FTX_IDLE: begin
          if (tx_en) begin
            state_nxt = ftx_pkg::FTX_SSD_J;
            code_nxt  = `FTX_CG_J;
          end else begin
            code_nxt  = `FTX_CG_IDLE;
          end
        end
        ftx_pkg::FTX_SSD_J: begin
          state_nxt = ftx_pkg::FTX_SSD_K;
          code_nxt  = `FTX_CG_K;
        end
        ftx_pkg::FTX_SSD_K,
        ftx_pkg::FTX_DATA: begin
          if (tx_en) begin
            state_nxt = ftx_pkg::FTX_DATA;
            code_nxt  = enc_4b5b(txd);
          end else begin
            state_nxt = ftx_pkg::FTX_ESD_T;
            code_nxt  = `FTX_CG_T;
          end
        end
        ftx_pkg::FTX_ESD_T: begin
          state_nxt = ftx_pkg::FTX_ESD_R;
          code_nxt  = `FTX_CG_R;
        end
        ftx_pkg::FTX_ESD_R: begin
          state_nxt = ftx_pkg::FTX_IDLE;
          code_nxt  = `FTX_CG_IDLE;
        end
        default: begin
          state_nxt = ftx_pkg::FTX_IDLE;
          code_nxt  = `FTX_CG_IDLE;
        end
      endcase
    end
  end

  // state advances only at group boundaries, never mid group
  // enable raised during t or r is acted on from idle only, so a back
  // to back frame always follows a complete end pair
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ftx_pkg::FTX_IDLE;
    end else if (slot_end) begin
      state_r <= state_nxt;
    end
  end

  // ============================================================
  // serialiser: load a group at the boundary, shift left otherwise
  // refilling with ones keeps a stray tail bit looking like idle
  // the left bit leaves first, in the order of the code table
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= `FTX_CG_IDLE;
    end else if (slot_end) begin
      shift_r <= code_nxt;
    end else begin
      shift_r <= {shift_r[3:0], 1'b1};
    end
  end

  // ============================================================
  // carrier sense and collision toward the mac
  // busy covers the end pair too, so in half duplex carrier holds until r has been
  // issued and the mac cannot start a new frame into the tail
  assign tx_busy = tx_en | (state_r != ftx_pkg::FTX_IDLE);

  // half duplex carrier
  // full duplex reports receive activity only, no echo of own transmit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crs_r <= 1'b0;
    end else begin
      crs_r <= rx_active | (tx_busy & ~full_dup);
    end
  end

  // full duplex no collision
  // loopback also suppresses collision: the line carries nothing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      col_r <= 1'b0;
    end else begin
      col_r <= tx_busy & rx_active & ~full_dup & ~loop_on;
    end
  end

  assign crs = crs_r;
  assign col = col_r;

  // ============================================================
  // line stage: scrambler, nrzi and mlt-3 split
  // kept behind the serial interface so the coding side needs no
  // knowledge of the key stream or of the line phase
  assign ser.code_bit = shift_r[4];
  assign ser.byp_scr  = byp_scr;
  // no line in loopback
  // only the 100 Mb/s path lives here, so 10 Mb/s keeps this line quiet
  assign ser.line_en  = speed100 & ~loop_on;

  ftx_line_stage u_line (
    .clk  (clk),
    .rstn (rstn),
    .ser  (ser.line)
  );

  assign line_p   = ser.line_p;
  assign line_n   = ser.line_n;
  assign lb_bit   = ser.lb_bit;
  // valid follows the control bit with no settling delay, so the
  // first bits after a switch may still carry the old line state
  assign lb_valid = loop_on;

endmodule : ftx_tx_pcs

// File: inc/ftx_cfg.svh
// constants of the fast ethernet transmit coding path
`ifndef FTX_CFG_SVH
`define FTX_CFG_SVH

// ============================================================
// register offsets (byte addresses)
`define FTX_OFS_MODE_CTRL 8'h80
`define FTX_OFS_PHYSTS    8'hC0
`define FTX_OFS_TXCFG     8'hCC

// ============================================================
// basic mode control fields and reset value
`define FTX_MODE_CTRL_LOOP   14
`define FTX_MODE_CTRL_SPEED  13
`define FTX_MODE_CTRL_DUPLEX 8
`define FTX_MODE_CTRL_RST    16'h2000
`define FTX_MODE_CTRL_WMASK  16'h6100

// ============================================================
// status fields
`define FTX_STS_LOOP      3
`define FTX_STS_DUPLEX    2
`define FTX_STS_SPEED10   1

// ============================================================
// transmit configuration fields and reset value
`define FTX_CFG_BYP_ENC   0
`define FTX_CFG_BYP_SCR   1
`define FTX_CFG_ACT       4
`define FTX_CFG_STATE_LSB 8
`define FTX_CFG_RST       2'h0

// ============================================================
// code-group slot timing and scrambler seed
`define FTX_SLOT_LAST     3'h4
`define FTX_SCR_SEED      11'h7FF

// ============================================================
// control code-groups, sent left bit first
`define FTX_CG_J          5'h18
`define FTX_CG_K          5'h11
`define FTX_CG_T          5'h0D
`define FTX_CG_R          5'h07
`define FTX_CG_IDLE       5'h1F

`endif

// File: inc/ftx_pkg.sv
// types of the fast ethernet transmit coding path
package ftx_pkg;

  // ============================================================
  // transmit sequencer states, gray coded along the frame path
  typedef enum logic [2:0] {
    FTX_IDLE  = 3'h0,
    FTX_SSD_J = 3'h1,
    FTX_SSD_K = 3'h3,
    FTX_DATA  = 3'h2,
    FTX_ESD_T = 3'h6,
    FTX_ESD_R = 3'h7
  } ftx_state_t;

  typedef logic [4:0] ftx_code_t;

endpackage : ftx_pkg

// File: inc/ftx_ser_if.sv
// serial hand-over between code-group stage and line stage
`timescale 1ns/1ps

interface ftx_ser_if;
  logic code_bit;   // serial code-group bit, one per clock
  logic byp_scr;    // scrambler bypass
  logic line_en;    // line may be driven
  logic line_p;     // first mlt-3 drive stream
  logic line_n;     // second mlt-3 drive stream
  logic lb_bit;     // nrzi stream handed back toward receive

  modport pcs  (output code_bit, byp_scr, line_en,
                input  line_p, line_n, lb_bit);
  modport line (input  code_bit, byp_scr, line_en,
                output line_p, line_n, lb_bit);
endinterface : ftx_ser_if

// File: core/ftx_line_stage.sv
// scrambler, nrzi encoder and mlt-3 stream split
`timescale 1ns/1ps
`include "ftx_cfg.svh"

module ftx_line_stage (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // serial hand-over
  ftx_ser_if.line   ser
);

  logic [10:0] scr_r;
  logic        scr_fb;
  logic        nrz_bit;
  logic        nrzi_r;
  logic        phase_r;
  logic        p_r;
  logic        n_r;

  // ============================================================
  // scrambler
  // free running lfsr
  assign scr_fb = scr_r[10] ^ scr_r[8];

  // lockup guard: an all-zero register would freeze the key stream
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scr_r <= `FTX_SCR_SEED;
    end else if (scr_r == 11'h000) begin
      scr_r <= `FTX_SCR_SEED;
    end else begin
      scr_r <= {scr_r[9:0], scr_fb};
    end
  end

  assign nrz_bit = ser.byp_scr ? ser.code_bit : (ser.code_bit ^ scr_fb);

  // ============================================================
  // nrzi encoder, never bypassed
  // nrzi always on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nrzi_r <= 1'b0;
    end else if (nrz_bit) begin
      nrzi_r <= ~nrzi_r;
    end
  end

  // ============================================================
  // mlt-3 split: ones of the nrzi stream alternate between streams
  // alternate one events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 1'b0;
    end else if (nrzi_r) begin
      phase_r <= ~phase_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p_r <= 1'b0;
      n_r <= 1'b0;
    end else begin
      p_r <= ser.line_en & nrzi_r & ~phase_r;
      n_r <= ser.line_en & nrzi_r & phase_r;
    end
  end

  assign ser.line_p = p_r;
  assign ser.line_n = n_r;
  assign ser.lb_bit = nrzi_r;

endmodule : ftx_line_stage

// File: tb/ftx_tx_pcs_chk.sv
// port assertions of the transmit coding path
`timescale 1ns/1ps
`include "ftx_cfg.svh"
// ============================================================
// checker
module ftx_tx_pcs_chk (
  // clock, reset, register port
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // mac and line side
  input wire logic        tx_en,
  input wire logic        tx_nib_take,
  input wire logic        rx_active,
  input wire logic        crs,
  input wire logic        col,
  input wire logic        line_p,
  input wire logic        line_n,
  input wire logic        lb_valid
);
  logic fd_r;  // full duplex shadow
  logic lp_r;  // loopback shadow
  // shadow the control bits that steer carrier and line
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fd_r <= 1'b0;
      lp_r <= 1'b0;
    end else if (reg_wr && reg_addr == `FTX_OFS_MODE_CTRL) begin
      fd_r <= reg_wdata[8];
      lp_r <= reg_wdata[14];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_slot;
    tx_nib_take |=> !tx_nib_take [*4] ##1 tx_nib_take;
  endproperty
  a_slot: assert property (p_slot)
    else $error("nibble slot not five cycles");
  property p_sts;
    reg_rd && reg_addr == `FTX_OFS_PHYSTS
      |=> reg_rdata[3] == lp_r && reg_rdata[2] == fd_r;
  endproperty
  a_sts: assert property (p_sts)
    else $error("status bits wrong");
  // settled loopback leaves the line quiet
  property p_quiet;
    lb_valid && $past(lb_valid, 3) |-> !line_p && !line_n;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("line driven in loopback");
  property p_alt; line_p |-> !line_n ##1 !line_p; endproperty
  a_alt: assert property (p_alt)
    else $error("line streams not alternating");
  property p_crs_rx; rx_active |=> crs; endproperty
  a_crs_rx: assert property (p_crs_rx)
    else $error("no carrier on receive");
  property p_crs_tx; tx_en && !fd_r |=> crs; endproperty
  a_crs_tx: assert property (p_crs_tx)
    else $error("no carrier on transmit");
  property p_fd_col; fd_r |=> !col; endproperty
  a_fd_col: assert property (p_fd_col)
    else $error("collision in full duplex");
  property p_col_rx; !rx_active |=> !col; endproperty
  a_col_rx: assert property (p_col_rx)
    else $error("collision without receive");
endmodule // ftx_tx_pcs_chk

bind ftx_tx_pcs ftx_tx_pcs_chk u_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_en(tx_en), .tx_nib_take(tx_nib_take), .rx_active(rx_active),
  .crs(crs), .col(col), .line_p(line_p), .line_n(line_n),
  .lb_valid(lb_valid)
);

// File: tb/ftx_mac_model.sv
// mac model handing nibbles to the transmit path
`timescale 1ns/1ps
// ============================================================
// mac model
module ftx_mac_model (
  // clock and take pulse
  input wire logic  clk,
  input wire logic  tx_nib_take,
  // nibble lines
  output logic       tx_en,
  output logic [3:0] txd,
  output logic       tx_er
);
  initial begin
    tx_en = 1'b0;
    txd = 4'h0;
    tx_er = 1'b0;
  end
  // wait for the edge that takes the nibble on show
  task automatic take_wait();
    int n;
    n = 0;
    @(negedge clk);
    while (!tx_nib_take && n < 12) begin
      @(negedge clk);
      n++;
    end
    if (!tx_nib_take) begin
      ftx_tx_pcs_tb.errors++;
      ftx_tx_pcs_tb.stop_test();
    end
    @(posedge clk);
  endtask
  task automatic frame(input logic [4:0] q[$], input int gap);
    foreach (q[i]) begin
      tx_en <= 1'b1;
      {tx_er, txd} <= q[i];
      take_wait();
    end
    tx_en <= 1'b0;
    // released lines show the inverse, never a stale value
    {tx_er, txd} <= ~q[q.size() - 1];
    repeat (gap + 1) take_wait();
  endtask
endmodule // ftx_mac_model

// File: tb/ftx_tx_pcs_tb.sv
// self-checking bench of the transmit coding path
`timescale 1ns/1ps
// ============================================================
// bench
module ftx_tx_pcs_tb;
  // register port
  logic         clk, rstn, reg_wr, reg_rd;
  logic [7:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  // mac, carrier, line
  logic         tx_en, tx_er, tx_nib_take, rx_active;
  logic [3:0]   txd;
  logic         crs, col, line_p, line_n, lb_bit, lb_valid;
  // bench state
  int           errors, comparisons;
  logic [109:0] hist, pat, msk;
  logic [31:0]  bad, zer;
  logic         lv_q, lb_q, hit, col_s, crs_s, line_s, lb_s;
  logic [4:0]   q[$];
  logic [4:0]   cg[16];

  ftx_tx_pcs dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_en(tx_en), .txd(txd), .tx_er(tx_er),
    .tx_nib_take(tx_nib_take), .rx_active(rx_active), .crs(crs),
    .col(col), .line_p(line_p), .line_n(line_n), .lb_bit(lb_bit),
    .lb_valid(lb_valid));
  ftx_mac_model u_mac (.clk(clk), .tx_nib_take(tx_nib_take),
    .tx_en(tx_en), .txd(txd), .tx_er(tx_er));

  // line level changes back to nrz bits, the code bits once the scrambler is off; flags catch activity
  always @(posedge clk) begin
    hist <= {hist[108:0], (line_p | line_n) ^ lv_q};
    lv_q <= line_p | line_n;
    lb_q <= lb_bit;
    if (col) col_s <= 1'b1;
    if (crs) crs_s <= 1'b1;
    if (line_p | line_n) line_s <= 1'b1;
    if (lb_bit !== lb_q) lb_s <= 1'b1;
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  // one frame with receive activity rx, flags cleared once settled
  task automatic txr(input logic rx);
    @(posedge clk);
    rx_active <= rx;
    repeat (3) @(negedge clk);
    {col_s, crs_s, line_s, lb_s} = 4'h0;
    @(posedge clk);
    u_mac.frame(q, 3);
    repeat (10) @(posedge clk);
  endtask
  task automatic seek();
    hit = 1'b0;
    repeat (250) begin
      @(negedge clk);
      if ((hist & msk) === pat) hit = 1'b1;
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    {rstn, reg_wr, reg_rd, rx_active, lv_q, lb_q} = 6'h0;
    {reg_addr, reg_wdata} = 40'h0;
    {hist, errors, comparisons} = '0;
    cg = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // defaults, masking, read-only and unmapped places
    rdc(8'h80, 32'h2000);
    rdc(8'hCC, 32'h0);
    rdc(8'h84, 32'h0);
    wr(8'h80, 32'hFFFF9EFF);
    rdc(8'h80, 32'h0);
    wr(8'hC0, 32'hFFFFFFFF);
    rdc(8'hC0, 32'h2);
    wr(8'h80, 32'h2000);
    // idle stream obeys the eleven stage recurrence
    {bad, zer} = 64'h0;
    repeat (30) @(negedge clk);
    repeat (300) begin
      @(negedge clk);
      if (hist[0] !== (hist[9] ^ hist[11] ^ 1'b1)) bad++;
      if (hist[0] === 1'b0) zer++;
    end
    chk(bad, 32'h0);
    chk(32'(zer != 0), 32'h1);
    // whole frame through every data code, scrambler off
    wr(8'hCC, 32'h2);
    q = '{5'h05, 5'h05, 5'h05};
    pat = 110'({5'h18, 5'h11, 5'h0B});
    for (int i = 0; i < 16; i++) begin
      q.push_back(5'(i));
      pat = {pat[104:0], cg[i]};
    end
    pat = {pat[94:0], 5'h0D, 5'h07, 5'h1F};
    msk = '1;
    fork
      txr(1'b0);
      seek();
    join
    chk(32'(hit), 32'h1);
    chk(32'(crs_s), 32'h1);
    // raw slots when the encoder is bypassed
    wr(8'hCC, 32'h3);
    q = '{5'h15, 5'h00, 5'h1A};
    pat = 110'({5'h15, 5'h00, 5'h1A});
    msk = 110'(15'h7FFF);
    fork
      txr(1'b0);
      seek();
    join
    chk(32'(hit), 32'h1);
    wr(8'hCC, 32'h0);
    q = '{5'h05, 5'h05, 5'h0D};
    txr(1'b1);
    chk(32'(col_s), 32'h1);
    // full duplex: no collision, no carrier from transmit
    wr(8'h80, 32'h2100);
    rdc(8'hC0, 32'h4);
    txr(1'b1);
    chk(32'(col_s), 32'h0);
    txr(1'b0);
    chk(32'(crs_s), 32'h0);
    // loopback keeps the line silent yet codes the stream
    wr(8'h80, 32'h6000);
    rdc(8'hC0, 32'h8);
    chk(32'(lb_valid), 32'h1);
    txr(1'b0);
    chk(32'(line_s), 32'h0);
    chk(32'(lb_s), 32'h1);
    stop_test();
  end
endmodule // ftx_tx_pcs_tb
